// >>> rcg_run_command_generator.sv
// Run command generator: merges keypad, terminal and link run sources.
`timescale 1ns/1ps
`default_nettype none
`include "rcg_cfg.svh"
module rcg_run_command_generator
  import rcg_pkg::*;
#(
  parameter int WORD_W   = `RCG_WORD_W,
  parameter int FREQ_W   = `RCG_FREQ_W,
  parameter int TIMER_W  = `RCG_TIMER_W,
  parameter int TICK_DIV = `RCG_TICK_DIV
) (
  input  wire logic                      clock_in,
  input  wire logic                      rstn_in,
  input  wire rcg_pkg::rcg_src_t         run_source_in,
  input  wire logic                      key_run_in,
  input  wire logic                      key_run_forward_in,
  input  wire logic                      key_run_reverse_in,
  input  wire logic                      key_stop_in,
  input  wire logic                      run_forward_in,
  input  wire logic                      run_reverse_in,
  input  wire logic                      hold_assigned_in,
  input  wire logic                      three_wire_hold_in,
  input  wire logic                      link_command_enable_in,
  input  wire logic                      word_write_in,
  input  wire logic [WORD_W-1:0]         word_data_in,
  input  wire logic [`RCG_TERM_FN_W-1:0] forward_terminal_function_in,
  input  wire logic [`RCG_TERM_FN_W-1:0] reverse_terminal_function_in,
  input  wire logic [`RCG_PRIO_W-1:0]    stop_key_priority_in,
  input  wire logic [FREQ_W-1:0]         reference_freq_in,
  input  wire logic [FREQ_W-1:0]         starting_frequency_in,
  input  wire logic [FREQ_W-1:0]         stop_frequency_in,
  input  wire logic [FREQ_W-1:0]         lower_frequency_limit_in,
  input  wire logic                      lower_limit_action_in,
  input  wire logic                      command_loss_in,
  input  wire logic                      command_loss_response_in,
  input  wire logic                      timer_enable_in,
  input  wire logic [TIMER_W-1:0]        timer_load_in,
  input  wire logic                      overload_stop_enable_in,
  input  wire logic                      overload_in,
  input  wire logic                      overload_stop_setting_in,
  output logic [WORD_W-1:0]              link_run_command_word_out,
  output logic                           link_enable_out,
  output logic                           run_forward_out,
  output logic                           run_reverse_out,
  output rcg_pkg::rcg_decel_t            decel_select_out
);
  import rcg_pkg::*;

  logic [WORD_W-1:0] word_reg;
  logic              key_latch_reg;
  logic              key_dir_rev_reg;
  logic              hold_fwd_reg;
  logic              hold_rev_reg;
  logic              ovl_block_reg;
  logic              prio_stop_reg;
  logic              timer_expired;
  logic              run_fwd_next;
  logic              run_rev_next;

  function automatic logic prog_bit(input logic [`RCG_TERM_FN_W-1:0] fn,
                                    input logic [`RCG_TERM_FN_W-1:0] want,
                                    input logic bit_v);
    prog_bit = (fn == want) & bit_v;
  endfunction : prog_bit

  // Link word register.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) word_reg <= `RCG_WORD_RESET;
    else if (word_write_in) word_reg <= word_data_in;
  end

  wire link_prog_bit_a = word_reg[`RCG_BIT_PROG_A];
  wire link_prog_bit_b = word_reg[`RCG_BIT_PROG_B];
  // Programmable bits follow the function of the terminal they mirror.
  wire link_fwd = word_reg[`RCG_BIT_FWD]
                | prog_bit(forward_terminal_function_in, `RCG_FN_FWD, link_prog_bit_a)
                | prog_bit(reverse_terminal_function_in, `RCG_FN_FWD, link_prog_bit_b);
  wire link_rev = word_reg[`RCG_BIT_REV]
                | prog_bit(forward_terminal_function_in, `RCG_FN_REV, link_prog_bit_a)
                | prog_bit(reverse_terminal_function_in, `RCG_FN_REV, link_prog_bit_b);
  wire link_word_en = link_prog_bit_a | link_prog_bit_b
                    | word_reg[`RCG_BIT_FWD] | word_reg[`RCG_BIT_REV];
  wire link_sel = link_command_enable_in | (run_source_in == RCG_SRC_LINK);

  wire prio_on   = (stop_key_priority_in == `RCG_PRIO_ON_A)
                 | (stop_key_priority_in == `RCG_PRIO_ON_B);
  wire prio_stop = prio_on & key_stop_in;

  // Keypad run latch, cleared by stop or by timer expiry.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      key_latch_reg   <= 1'b0;
      key_dir_rev_reg <= 1'b0;
    end else if (key_stop_in || timer_expired) begin
      key_latch_reg <= 1'b0;
    end else if (run_source_in == RCG_SRC_KEYPAD && key_run_in) begin
      key_latch_reg <= 1'b1;
    end else if (run_source_in == RCG_SRC_MULTI_KEYPAD
                 && (key_run_forward_in ^ key_run_reverse_in)) begin
      key_latch_reg   <= 1'b1;
      key_dir_rev_reg <= key_run_reverse_in;
    end
  end

  // Three-wire hold latches; released when hold drops.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hold_fwd_reg <= 1'b0;
      hold_rev_reg <= 1'b0;
    end else if (!three_wire_hold_in) begin
      hold_fwd_reg <= 1'b0;
      hold_rev_reg <= 1'b0;
    end else begin
      hold_fwd_reg <= hold_fwd_reg | run_forward_in;
      hold_rev_reg <= hold_rev_reg | run_reverse_in;
    end
  end

  wire term_fwd = hold_assigned_in ? (hold_fwd_reg | run_forward_in) & three_wire_hold_in
                                   : run_forward_in;
  wire term_rev = hold_assigned_in ? (hold_rev_reg | run_reverse_in) & three_wire_hold_in
                                   : run_reverse_in;

  wire key_fwd = key_latch_reg & ((run_source_in == RCG_SRC_KEYPAD)
               ? (run_forward_in | !run_reverse_in) : !key_dir_rev_reg);
  wire key_rev = key_latch_reg & ((run_source_in == RCG_SRC_KEYPAD)
               ? (run_reverse_in & !run_forward_in) : key_dir_rev_reg);

  wire sel_fwd = link_sel ? link_fwd
               : (run_source_in == RCG_SRC_TERMINAL) ? term_fwd : key_fwd;
  wire sel_rev = link_sel ? link_rev
               : (run_source_in == RCG_SRC_TERMINAL) ? term_rev : key_rev;
  wire both_on = sel_fwd & sel_rev;
  wire any_req = sel_fwd | sel_rev;

  wire freq_low   = (reference_freq_in < starting_frequency_in)
                  | (reference_freq_in < stop_frequency_in);
  wire below_lim  = lower_limit_action_in
                  & (reference_freq_in < lower_frequency_limit_in);
  wire loss_stop  = command_loss_in & !command_loss_response_in;
  wire ovl_trip   = overload_stop_enable_in & overload_in & overload_stop_setting_in;

  // Overload stop holds off until the run request is removed.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) ovl_block_reg <= 1'b0;
    else if (ovl_trip) ovl_block_reg <= 1'b1;
    else if (!any_req) ovl_block_reg <= 1'b0;
  end

  rcg_tick_timer #(
    .TICK_DIV (TICK_DIV),
    .TIMER_W  (TIMER_W)
  ) u_timer (
    .clock_in    (clock_in),
    .rstn_in     (rstn_in),
    .enable_in   (timer_enable_in & any_req),
    .start_in    (any_req),
    .load_in     (timer_load_in),
    .expired_out (timer_expired)
  );

  wire kill = both_on | prio_stop | freq_low | below_lim | loss_stop
            | ovl_trip | ovl_block_reg | timer_expired;
  assign run_fwd_next = sel_fwd & !kill;
  assign run_rev_next = sel_rev & !kill;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      run_forward_out           <= 1'b0;
      run_reverse_out           <= 1'b0;
      link_enable_out           <= 1'b0;
      prio_stop_reg             <= 1'b0;
      decel_select_out          <= RCG_DECEL_CFG;
      link_run_command_word_out <= `RCG_WORD_RESET;
    end else begin
      run_forward_out           <= run_fwd_next;
      run_reverse_out           <= run_rev_next;
      link_enable_out           <= link_word_en;
      link_run_command_word_out <= word_reg;
      if (prio_stop) prio_stop_reg <= 1'b1;
      else if (any_req && !key_stop_in) prio_stop_reg <= 1'b0;
      decel_select_out <= (prio_stop || (prio_stop_reg && !any_req))
                        ? RCG_DECEL_LINEAR : RCG_DECEL_CFG;
    end
  end

  a_conflict_off: assert property (@(posedge clock_in) disable iff (!rstn_in)
    both_on |=> !run_forward_out && !run_reverse_out)
    else $error("Both runs requested but an output stayed on.");
  a_prio_stop_off: assert property (@(posedge clock_in) disable iff (!rstn_in)
    prio_stop |=> !run_forward_out && !run_reverse_out && decel_select_out == RCG_DECEL_LINEAR)
    else $error("Priority stop did not drop the run linearly.");
  a_freq_low_off: assert property (@(posedge clock_in) disable iff (!rstn_in)
    freq_low |=> !(run_forward_out || run_reverse_out))
    else $error("Run stayed on below start or stop frequency.");
  a_lower_lim_off: assert property (@(posedge clock_in) disable iff (!rstn_in)
    below_lim |=> !(run_forward_out || run_reverse_out))
    else $error("Run stayed on below lower limit.");
  a_loss_off: assert property (@(posedge clock_in) disable iff (!rstn_in)
    loss_stop |=> !(run_forward_out || run_reverse_out))
    else $error("Run stayed on after command loss.");
  a_link_enable: assert property (@(posedge clock_in) disable iff (!rstn_in)
    link_word_en |=> link_enable_out)
    else $error("Link enable missing for set run bits.");
  a_link_fwd_bit: assert property (@(posedge clock_in) disable iff (!rstn_in)
    link_sel && word_reg[`RCG_BIT_FWD] && !word_reg[`RCG_BIT_REV] && !link_rev && !kill
    |=> run_forward_out)
    else $error("Link forward bit did not run forward.");
  a_timer_clear: assert property (@(posedge clock_in) disable iff (!rstn_in)
    timer_expired |=> !key_latch_reg && !run_forward_out && !run_reverse_out)
    else $error("Timer expiry left run or keypad latch on.");
  a_ovl_restart: assert property (@(posedge clock_in) disable iff (!rstn_in)
    ovl_trip ##1 any_req |=> !(run_forward_out || run_reverse_out))
    else $error("Run restarted without removing the command after overload.");
  a_two_wire: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !hold_assigned_in && run_source_in == RCG_SRC_TERMINAL && !link_sel
    && run_forward_in && !run_reverse_in && !kill |=> run_forward_out)
    else $error("Two-wire forward level did not run.");

  // A forward press seen while the hold terminal is active, then hold staying active.
  sequence s_hold_fwd_press;
    hold_assigned_in && three_wire_hold_in && run_forward_in;
  endsequence : s_hold_fwd_press
  sequence s_hold_kept;
    hold_assigned_in && three_wire_hold_in;
  endsequence : s_hold_kept
  // A lone reverse key on the multi-function keypad with nothing clearing the latch.
  sequence s_multi_rev_press;
    run_source_in == RCG_SRC_MULTI_KEYPAD && key_run_reverse_in && !key_run_forward_in
    && !key_stop_in && !timer_expired;
  endsequence : s_multi_rev_press

  // Keypad latch checks: stop always wins over a run key in the same cycle.
  a_key_run_latch: assert property (@(posedge clock_in) disable iff (!rstn_in)
    run_source_in == RCG_SRC_KEYPAD && key_run_in && !key_stop_in && !timer_expired
    |=> key_latch_reg)
    else $error("Keypad run key did not latch the run.");
  a_key_stop_clear: assert property (@(posedge clock_in) disable iff (!rstn_in)
    key_stop_in |=> !key_latch_reg)
    else $error("Stop key left the keypad latch set.");
  a_key_dir_rev: assert property (@(posedge clock_in) disable iff (!rstn_in)
    run_source_in == RCG_SRC_KEYPAD && !link_sel && key_latch_reg && run_reverse_in
    && !run_forward_in && !kill |=> run_reverse_out && !run_forward_out)
    else $error("Keypad run did not follow the reverse input.");
  a_multi_latch: assert property (@(posedge clock_in) disable iff (!rstn_in)
    s_multi_rev_press |=> key_latch_reg && key_dir_rev_reg)
    else $error("Multi-function reverse key did not latch reverse.");
  a_multi_release: assert property (@(posedge clock_in) disable iff (!rstn_in)
    run_source_in == RCG_SRC_MULTI_KEYPAD && key_stop_in |=> !key_latch_reg)
    else $error("Stop key did not release the multi-function latch.");
  a_hold_latch: assert property (@(posedge clock_in) disable iff (!rstn_in)
    s_hold_fwd_press ##1 s_hold_kept |-> term_fwd)
    else $error("Three-wire hold lost the forward command.");
  a_hold_release: assert property (@(posedge clock_in) disable iff (!rstn_in)
    hold_assigned_in && !three_wire_hold_in |-> !term_fwd && !term_rev)
    else $error("Terminal run stayed on with hold released.");
  a_two_wire_rev: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !hold_assigned_in && run_source_in == RCG_SRC_TERMINAL && !link_sel
    && run_reverse_in && !run_forward_in && !kill |=> run_reverse_out)
    else $error("Two-wire reverse level did not run.");
  // Link word checks: the stored word reaches the output port two edges after the strobe.
  a_link_rev_bit: assert property (@(posedge clock_in) disable iff (!rstn_in)
    link_sel && word_reg[`RCG_BIT_REV] && !word_reg[`RCG_BIT_FWD] && !link_fwd && !kill
    |=> run_reverse_out)
    else $error("Link reverse bit did not run reverse.");
  a_word_copy: assert property (@(posedge clock_in) disable iff (!rstn_in)
    word_write_in |=> ##1 link_run_command_word_out == $past(word_data_in, 2))
    else $error("Link run word was not stored as written.");
  a_prog_bit_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    link_sel && link_prog_bit_a && forward_terminal_function_in == `RCG_FN_REV
    && !link_fwd && !kill |=> run_reverse_out)
    else $error("Programmable bit A did not follow its terminal function.");
  a_prog_bit_b: assert property (@(posedge clock_in) disable iff (!rstn_in)
    link_sel && link_prog_bit_b && reverse_terminal_function_in == `RCG_FN_FWD
    && !link_rev && !kill |=> run_forward_out)
    else $error("Programmable bit B did not follow its terminal function.");
  a_link_enable_off: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !link_word_en |=> !link_enable_out)
    else $error("Link enable set with no run bits in the word.");
  a_linear_hold: assert property (@(posedge clock_in) disable iff (!rstn_in)
    prio_stop_reg && !any_req |=> decel_select_out == RCG_DECEL_LINEAR)
    else $error("Deceleration left linear before the run was reapplied.");
  a_ovl_trip_off: assert property (@(posedge clock_in) disable iff (!rstn_in)
    ovl_trip |=> ovl_block_reg && !run_forward_out && !run_reverse_out)
    else $error("Overload trip did not block the run.");
  a_link_source: assert property (@(posedge clock_in) disable iff (!rstn_in)
    link_command_enable_in && !link_fwd && !link_rev
    |=> !run_forward_out && !run_reverse_out)
    else $error("Link enable did not take the run source to the link.");
endmodule : rcg_run_command_generator
`default_nettype wire

// >>> rcg_cfg.svh
// Constants for the run command generator.
`ifndef RCG_CFG_SVH
`define RCG_CFG_SVH
`define RCG_WORD_W        16
`define RCG_BIT_FWD       0
`define RCG_BIT_REV       1
`define RCG_BIT_PROG_A    13
`define RCG_BIT_PROG_B    14
`define RCG_WORD_RESET    16'h0000
`define RCG_FREQ_W        16
`define RCG_TIMER_W       32
`define RCG_TICK_DIV      40000
`define RCG_TICK_W        16
`define RCG_TERM_FN_W     8
`define RCG_FN_FWD        8'h62
`define RCG_FN_REV        8'h63
`define RCG_PRIO_W        2
`define RCG_PRIO_ON_A     2'h1
`define RCG_PRIO_ON_B     2'h3
`endif

// >>> rcg_pkg.sv
// Types shared by the run command generator.
package rcg_pkg;
  typedef enum logic [1:0] {RCG_SRC_KEYPAD, RCG_SRC_MULTI_KEYPAD, RCG_SRC_TERMINAL,
                            RCG_SRC_LINK} rcg_src_t;
  typedef enum logic [1:0] {RCG_DECEL_CFG, RCG_DECEL_LINEAR} rcg_decel_t;
endpackage : rcg_pkg

// >>> rcg_tick_timer.sv
// Millisecond tick divider and run timer countdown.
`timescale 1ns/1ps
`default_nettype none
`include "rcg_cfg.svh"
module rcg_tick_timer #(
  parameter int TICK_DIV = `RCG_TICK_DIV,
  parameter int TIMER_W  = `RCG_TIMER_W
) (
  input  wire logic               clock_in,
  input  wire logic               rstn_in,
  input  wire logic               enable_in,
  input  wire logic               start_in,
  input  wire logic [TIMER_W-1:0] load_in,
  output logic                    expired_out
);
  logic [`RCG_TICK_W-1:0] div_reg;
  logic [TIMER_W-1:0]     count_reg;
  logic                   running_reg;
  wire                    tick = (div_reg == `RCG_TICK_W'(TICK_DIV - 1));

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) div_reg <= '0;
    else div_reg <= tick ? '0 : div_reg + 1'b1;
  end

  // Counts down in ticks while armed; expiry is a one-cycle pulse.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_reg   <= '0;
      running_reg <= 1'b0;
      expired_out <= 1'b0;
    end else begin
      expired_out <= 1'b0;
      if (!enable_in) begin
        running_reg <= 1'b0;
      end else if (start_in && !running_reg) begin
        count_reg   <= load_in;
        running_reg <= 1'b1;
      end else if (running_reg && tick) begin
        if (count_reg == '0) begin
          running_reg <= 1'b0;
          expired_out <= 1'b1;
        end else begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end
endmodule : rcg_tick_timer
`default_nettype wire

// >>> rcg_host_model.sv
// Link host model that writes the run command word with a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
`include "rcg_cfg.svh"
module rcg_host_model (
  input  wire logic                   clock_in,
  output logic                        word_write_out,
  output logic [`RCG_WORD_W-1:0]      word_data_out
);
  initial begin
    word_write_out = 1'b0;
    word_data_out  = 16'hFFFF;
  end
  // The word goes out whole with the strobe; once released the data lines show its inverse.
  task automatic send(input logic [`RCG_WORD_W-1:0] w);
    @(negedge clock_in);
    word_write_out = 1'b1;
    word_data_out  = w;
    @(negedge clock_in);
    word_write_out = 1'b0;
    word_data_out  = ~w;
  endtask : send
endmodule : rcg_host_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the run command generator.
`timescale 1ns/1ps
`default_nettype none
`include "rcg_cfg.svh"
module tb_top;
  import rcg_pkg::*;
  localparam logic [65:0] FQ [6] = '{
    {16'h03E8, 16'h0064, 16'h0032, 16'h00C8, 2'h3},
    {16'h0063, 16'h0064, 16'h0032, 16'h0000, 2'h2},
    {16'h0064, 16'h0064, 16'h0096, 16'h0000, 2'h2},
    {16'h0096, 16'h0064, 16'h0032, 16'h00C8, 2'h2},
    {16'h0096, 16'h0064, 16'h0032, 16'h00C8, 2'h1},
    {16'h0064, 16'h0064, 16'h0032, 16'h0000, 2'h3}};
  logic clock_in, rstn_in, k_run, k_fwd, k_rev, k_stop, t_fwd, t_rev, hold_as, hold, lce;
  logic ll_act, loss, loss_rsp, tmr_en, ov_en, ov, ov_set, wr, le_o, fwd_o, rev_o, f, r;
  rcg_src_t    src;
  rcg_decel_t  dec_o;
  logic [7:0]  fn_f, fn_r;
  logic [1:0]  prio;
  logic [15:0] f_ref, f_start, f_stop, f_low, wdata, word_o, exp_word, w;
  logic [31:0] tmr_load, rng;
  logic [20:0] notes[$];
  event        look;
  int          n_mismatch, samples_checked;

  rcg_host_model host (.clock_in(clock_in), .word_write_out(wr), .word_data_out(wdata));
  rcg_run_command_generator #(.TICK_DIV(4)) DUT (
    .clock_in(clock_in), .rstn_in(rstn_in), .run_source_in(src), .key_run_in(k_run),
    .key_run_forward_in(k_fwd), .key_run_reverse_in(k_rev), .key_stop_in(k_stop),
    .run_forward_in(t_fwd), .run_reverse_in(t_rev), .hold_assigned_in(hold_as),
    .three_wire_hold_in(hold), .link_command_enable_in(lce), .word_write_in(wr),
    .word_data_in(wdata), .forward_terminal_function_in(fn_f),
    .reverse_terminal_function_in(fn_r), .stop_key_priority_in(prio),
    .reference_freq_in(f_ref), .starting_frequency_in(f_start), .stop_frequency_in(f_stop),
    .lower_frequency_limit_in(f_low), .lower_limit_action_in(ll_act),
    .command_loss_in(loss), .command_loss_response_in(loss_rsp), .timer_enable_in(tmr_en),
    .timer_load_in(tmr_load), .overload_stop_enable_in(ov_en), .overload_in(ov),
    .overload_stop_setting_in(ov_set), .link_run_command_word_out(word_o),
    .link_enable_out(le_o), .run_forward_out(fwd_o), .run_reverse_out(rev_o),
    .decel_select_out(dec_o));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // The expected snapshot also carries the stored word and its link enable.
  task automatic note(input logic ef, input logic er, input logic lin);
    notes.push_back({exp_word, |{exp_word[14:13], exp_word[1:0]}, ef, er, 1'b0, lin});
    -> look;
  endtask : note
  task automatic step(input int n);
    repeat (n) @(negedge clock_in);
  endtask : step
  task automatic do_reset;
    rstn_in = 1'b0;
    step(4);
    rstn_in = 1'b1;
    exp_word = 16'h0000;
  endtask : do_reset
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  initial forever begin
    @(look);
    chk({word_o, le_o, fwd_o, rev_o, dec_o}, notes.pop_front());
  end
  initial begin
    #(25 * 5000);
    n_mismatch++;
    summarize;
  end

  initial begin
    {k_run, k_fwd, k_rev, k_stop, t_fwd, t_rev, hold_as, hold, lce, loss, loss_rsp} = '0;
    {tmr_en, ov_en, ov, ov_set, prio, ll_act} = 7'h01;
    src = RCG_SRC_KEYPAD;
    {fn_f, fn_r} = {`RCG_FN_FWD, `RCG_FN_REV};
    {f_ref, f_start, f_stop, f_low} = FQ[0][65:2];
    {tmr_load, rng} = {32'h00000002, 32'h578E17AA};
    do_reset;
    note(1'b0, 1'b0, 1'b0);
    t_rev = 1'b1;
    k_run = 1'b1;
    step(1);
    k_run = 1'b0;
    step(2);
    note(1'b0, 1'b1, 1'b0);
    k_stop = 1'b1;
    step(1);
    {k_stop, t_rev} = '0;
    step(2);
    note(1'b0, 1'b0, 1'b0);
    src = RCG_SRC_MULTI_KEYPAD;
    k_rev = 1'b1;
    step(1);
    k_rev = 1'b0;
    step(2);
    note(1'b0, 1'b1, 1'b0);
    k_stop = 1'b1;
    step(1);
    k_stop = 1'b0;
    step(2);
    note(1'b0, 1'b0, 1'b0);
    src = RCG_SRC_TERMINAL;
    t_fwd = 1'b1;
    step(2);
    note(1'b1, 1'b0, 1'b0);
    t_rev = 1'b1;
    step(2);
    note(1'b0, 1'b0, 1'b0);
    t_fwd = 1'b0;
    step(2);
    note(1'b0, 1'b1, 1'b0);
    {t_fwd, t_rev, hold_as, hold} = 4'hB;
    step(1);
    t_fwd = 1'b0;
    step(2);
    note(1'b1, 1'b0, 1'b0);
    hold = 1'b0;
    step(2);
    note(1'b0, 1'b0, 1'b0);
    hold_as = 1'b0;
    for (int p = 0; p < 4; p++) begin
      prio = p[1:0];
      t_fwd = 1'b1;
      step(2);
      k_stop = 1'b1;
      step(2);
      note(~p[0], 1'b0, p[0]);
      {k_stop, t_fwd} = '0;
      step(2);
      note(1'b0, 1'b0, p[0]);
      do_reset;
    end
    prio = 2'h0;
    t_fwd = 1'b1;
    for (int i = 0; i < 6; i++) begin
      {f_ref, f_start, f_stop, f_low, ll_act} = FQ[i][65:1];
      step(2);
      note(FQ[i][0], 1'b0, 1'b0);
    end
    {loss, loss_rsp} = 2'h3;
    step(2);
    note(1'b1, 1'b0, 1'b0);
    loss_rsp = 1'b0;
    step(2);
    note(1'b0, 1'b0, 1'b0);
    {loss, t_fwd} = '0;
    step(1);
    {t_fwd, ov_en, ov, ov_set} = 4'hF;
    step(2);
    note(1'b0, 1'b0, 1'b0);
    ov = 1'b0;
    step(2);
    note(1'b0, 1'b0, 1'b0);
    t_fwd = 1'b0;
    step(1);
    t_fwd = 1'b1;
    step(2);
    note(1'b1, 1'b0, 1'b0);
    {t_fwd, ov_en, ov_set, tmr_en} = 4'h1;
    src = RCG_SRC_KEYPAD;
    k_run = 1'b1;
    step(1);
    k_run = 1'b0;
    step(2);
    note(1'b1, 1'b0, 1'b0);
    step(20);
    note(1'b0, 1'b0, 1'b0);
    tmr_en = 1'b0;
    step(2);
    note(1'b0, 1'b0, 1'b0);
    src = RCG_SRC_TERMINAL;
    lce = 1'b1;
    for (int i = 0; i < 24; i++) begin
      rng = xs(rng);
      w = rng[15:0];
      {fn_f, fn_r} = i[0] ? {`RCG_FN_REV, `RCG_FN_FWD} : {`RCG_FN_FWD, `RCG_FN_REV};
      host.send(w);
      exp_word = w;
      f = w[0] | (i[0] ? w[14] : w[13]);
      r = w[1] | (i[0] ? w[13] : w[14]);
      step(2);
      note(f & ~r, r & ~f, 1'b0);
    end
    host.send(16'h0001);
    {exp_word, lce} = {16'h0001, 1'b0};
    step(2);
    note(1'b0, 1'b0, 1'b0);
    src = RCG_SRC_LINK;
    step(2);
    note(1'b1, 1'b0, 1'b0);
    step(1);
    summarize;
  end
endmodule : tb_top
`default_nettype wire
